/* rtl/ext_irq_pkg.sv */
// Constants, codes and bus carrier for the external pin interrupt unit
// Summary of operation
// - Pin activity raises enabled interrupts even while software drives the pin as output.
// - Enabled low-level channel keeps requesting while its pin stays low, except during power-down.
// - Edges on all channels need the clock, channels 3:0 via a two-stage synchroniser; level wake-up reads raw pins.
// - Power-down level wake-up needs the level seen on two watchdog samples.
// - Level gone before start-up ends: wake anyway, but raise no request.
// - Channels 3:0 sense: 00 low level, 01 reserved, 10 falling, 11 rising.
// - Channels 7:4 sense: 00 low level, 01 any change, 10 falling, 11 rising.
// - Channels 7:4 sample pins first; pulses over one clock period are caught.
// - Channel interrupts CPU only with global enable and its mask bit set.
// - A qualifying edge or change on a pin sets its request flag.
// - Flag clears on interrupt entry or when software writes one to it.
// - Flag is held cleared while its channel is in level sensing.
// - Sleep with channels 3:0 masked disables their input buffers; flags may set.
// - Sense registers hold four two-bit fields, higher channel higher; reset zero.
// - Legacy mode hides lower sense register; channels 3:0 stay low-level.
package ext_irq_pkg;
	localparam int CHANNELS = 8;
	localparam int LOW_CHANNELS = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register byte addresses
	localparam logic [7:0] OFS_FLAGS      = 8'h58;
	localparam logic [7:0] OFS_MASK       = 8'h59;
	localparam logic [7:0] OFS_SENSE_HIGH = 8'h5A;
	localparam logic [7:0] OFS_SENSE_LOW  = 8'h6A;

	// Values after reset
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [7:0] RST_SENSE = 8'h00;

	// Two-bit sense codes
	localparam logic [1:0] SENSE_LEVEL   = 2'h0;
	localparam logic [1:0] SENSE_CHANGE  = 2'h1;
	localparam logic [1:0] SENSE_FALLING = 2'h2;
	localparam logic [1:0] SENSE_RISING  = 2'h3;

	// Watchdog samples needed before a level wake-up
	localparam logic [1:0] WAKE_SAMPLES = 2'h2;

	// One register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;
endpackage

/* rtl/external_pin_interrupt_unit.sv */
// Eight-channel external pin interrupt unit with register port and wake-up logic
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit (
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	input  wire ext_irq_pkg::reg_req_s  bus_req,
	output logic [7:0]                  rdata,
	input  wire logic [7:0]             ext_irq_pins,
	input  wire logic                   global_irq_enable,
	input  wire logic                   irq_ack,
	input  wire logic [2:0]             irq_ack_channel,
	input  wire logic                   legacy_mode,
	input  wire logic                   sleep_active,
	input  wire logic                   power_down,
	input  wire logic                   wdt_tick,
	input  wire logic                   startup_done,
	output logic [7:0]                  irq_req,
	output logic                        irq,
	output logic                        wake_req
);
	logic [7:0] flags;
	logic [7:0] mask;
	logic [7:0] sense_high;
	logic [7:0] sense_low;
	logic [7:0] pin_eff;
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] low_prev;
	logic [3:0] high_cur;
	logic [3:0] high_prev;
	logic [7:0] hit;
	logic [7:0] level_mode;
	logic [7:0] level_low;
	logic [7:0] ack_clr;
	logic [7:0] wr_clr;
	logic [7:0] next_flags;
	logic [7:0] next_req;
	logic [1:0] wake_cnt;
	logic       wake_level;
	logic [15:0] sense_all;
	logic       bus_wr;
	logic       bus_rd;

	// Sense code of one channel out of the packed sense pair
	function automatic logic [1:0] sense_of(input logic [15:0] s, input int ch);
		sense_of = s[2*ch +: 2];
	endfunction

	// Edge or change decision between a previous and a current sample
	function automatic logic edge_hit(input logic [1:0] s, input logic prev, input logic cur,
		input logic upper);
		unique case (s)
			ext_irq_pkg::SENSE_LEVEL:   edge_hit = 1'b0;
			ext_irq_pkg::SENSE_CHANGE:  edge_hit = upper & (prev ^ cur);
			ext_irq_pkg::SENSE_FALLING: edge_hit = prev & ~cur;
			ext_irq_pkg::SENSE_RISING:  edge_hit = ~prev & cur;
		endcase
	endfunction

	assign bus_wr = bus_req.wr;
	assign bus_rd = bus_req.rd;

	// Legacy mode pins the lower field at its reset code, so channels 3:0 stay low-level
	assign sense_all = {sense_high, legacy_mode ? ext_irq_pkg::RST_SENSE : sense_low};

	// Masked low channels lose their input buffer in sleep; the buffer then reads low
	assign pin_eff = {ext_irq_pins[7:4],
		ext_irq_pins[3:0] & ~({4{sleep_active}} & ~mask[3:0])};

	// Low channels: two-stage synchroniser ahead of edge detection
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sync_a <= 4'hF;
			sync_b <= 4'hF;
			low_prev <= 4'hF;
		end else begin
			sync_a <= pin_eff[3:0];
			sync_b <= sync_a;
			low_prev <= sync_b;
		end
	end

	// High channels: one sample per clock, edges judged between successive samples
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			high_cur <= 4'hF;
			high_prev <= 4'hF;
		end else begin
			high_cur <= pin_eff[7:4];
			high_prev <= high_cur;
		end
	end

	// Event detection; pins are read regardless of their port direction
	always_comb begin
		for (int i = 0; i < ext_irq_pkg::CHANNELS; i++) begin
			level_mode[i] = (sense_of(sense_all, i) == ext_irq_pkg::SENSE_LEVEL);
		end
		for (int i = 0; i < ext_irq_pkg::LOW_CHANNELS; i++) begin
			hit[i] = edge_hit(sense_of(sense_all, i), low_prev[i], sync_b[i], 1'b0);
			level_low[i] = ~sync_b[i];
		end
		for (int i = 0; i < ext_irq_pkg::LOW_CHANNELS; i++) begin
			hit[i+4] = edge_hit(sense_of(sense_all, i+4), high_prev[i], high_cur[i], 1'b1);
			level_low[i+4] = ~high_cur[i];
		end
	end

	// Flag clears from vector entry and from write-one
	always_comb begin
		ack_clr = '0;
		if (irq_ack) begin
			ack_clr[irq_ack_channel] = 1'b1;
		end
		wr_clr = (bus_wr && bus_req.addr == ext_irq_pkg::OFS_FLAGS) ? bus_req.wdata : 8'h00;
	end

	// Set wins over clear; level mode forces the flag low
	assign next_flags = (hit | (flags & ~ack_clr & ~wr_clr)) & ~level_mode;

	// Requests to the CPU; level channels request while low and never in power-down
	assign next_req = {8{global_irq_enable}} & mask &
		((flags & ~level_mode) | (level_mode & level_low & {8{~power_down}}));

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			flags <= ext_irq_pkg::RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

	// Registered request vector and combined level interrupt
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			irq_req <= 8'h00;
			irq <= 1'b0;
		end else begin
			irq_req <= next_req;
			irq <= |next_req;
		end
	end

	// Register writes; the lower sense register is unreachable in legacy mode
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mask <= ext_irq_pkg::RST_MASK;
			sense_high <= ext_irq_pkg::RST_SENSE;
			sense_low <= ext_irq_pkg::RST_SENSE;
		end else if (bus_wr) begin
			unique case (bus_req.addr)
				ext_irq_pkg::OFS_MASK: begin
					mask <= bus_req.wdata;
				end
				ext_irq_pkg::OFS_SENSE_HIGH: begin
					sense_high <= bus_req.wdata;
				end
				ext_irq_pkg::OFS_SENSE_LOW: begin
					if (!legacy_mode) begin
						sense_low <= bus_req.wdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stand the cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (bus_rd) begin
			unique case (bus_req.addr)
				ext_irq_pkg::OFS_FLAGS:      rdata <= flags;
				ext_irq_pkg::OFS_MASK:       rdata <= mask;
				ext_irq_pkg::OFS_SENSE_HIGH: rdata <= sense_high;
				ext_irq_pkg::OFS_SENSE_LOW:  rdata <= legacy_mode ? 8'h00 : sense_low;
				default:                     rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Any enabled low-level channel whose pin is low can wake; raw pins, no clock edge needed
	assign wake_level = |(mask & level_mode & ~pin_eff);

	// Two consecutive watchdog samples filter noise before wake-up starts
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wake_cnt <= 2'h0;
			wake_req <= 1'b0;
		end else if (!power_down) begin
			wake_cnt <= 2'h0;
			wake_req <= 1'b0;
		end else if (wdt_tick) begin
			if (!wake_level) begin
				wake_cnt <= 2'h0;
			end else if (wake_cnt != ext_irq_pkg::WAKE_SAMPLES) begin
				wake_cnt <= wake_cnt + 2'h1;
			end
			if (wake_level && wake_cnt == ext_irq_pkg::WAKE_SAMPLES - 2'h1) begin
				wake_req <= 1'b1;
			end
		end
	end

	// Wake stays asserted even if the level leaves; start-up end is reported elsewhere
	logic startup_seen;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			startup_seen <= 1'b0;
		end else begin
			startup_seen <= startup_done & wake_req;
		end
	end

	// Flag checks: level mode forces the flag low, edges set it, clears need a cause
	chk_flag_level_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(flags & level_mode) == 8'h00)
		else $error("flag set in level mode");

	// An edge on an upper channel lands in its flag one edge later
	chk_edge_sets_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
		hit[7] |=> flags[7])
		else $error("edge did not set flag");

	// Write-one clear with no competing edge
	chk_w1c_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_clr[0] && !hit[0]) |=> !flags[0])
		else $error("write one did not clear");

	// Writing zero or no write must not drop a flag
	chk_write_zero_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
		(flags[1] && !wr_clr[1] && !ack_clr[1]) |=> flags[1] || level_mode[1])
		else $error("flag lost without clear");

	// Vector entry clears the acknowledged channel only
	chk_ack_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
		(irq_ack && irq_ack_channel == 3'h7 && !hit[7]) |=> !flags[7])
		else $error("ack did not clear flag");

	// Set wins when an edge meets a write-one clear in the same cycle
	chk_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
		(hit[4] && wr_clr[4]) |=> flags[4])
		else $error("clear beat a new edge");

	// A flag only ever rises because of a detected edge
	chk_flag_rise_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(flags[7]) |-> $past(hit[7]))
		else $error("flag set without edge");

	// Request gating: the global enable and the mask bit both have to be on
	chk_gate_global: assert property (@(posedge ref_clk) disable iff (!resetn)
		!$past(global_irq_enable) |-> irq_req == 8'h00)
		else $error("request without enable");

	// A masked channel never requests
	chk_req_needs_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
		!$past(mask[4]) |-> !irq_req[4])
		else $error("request on masked channel");

	// A pending edge flag reaches the CPU when enabled
	chk_flag_requests: assert property (@(posedge ref_clk) disable iff (!resetn)
		(flags[7] && !level_mode[7] && mask[7] && global_irq_enable) |=> irq_req[7])
		else $error("pending flag not requested");

	// Level channels request for as long as the pin stays low
	chk_level_request: assert property (@(posedge ref_clk) disable iff (!resetn)
		(global_irq_enable && mask[6] && level_mode[6] && !high_cur[2] && !power_down)
		|=> irq_req[6])
		else $error("low level not requested");

	// Power-down blocks level requests, so a level gone by start-up end asks nothing
	chk_power_down_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		(power_down && level_mode[5]) |=> !irq_req[5])
		else $error("level request during power-down");

	// The combined line follows the request vector exactly
	chk_irq_matches: assert property (@(posedge ref_clk) disable iff (!resetn)
		irq == |irq_req)
		else $error("irq out of step with requests");

	// Sampling paths: lower channels through two stages, upper through one
	chk_low_sync_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sense_of(sense_all, 3) == ext_irq_pkg::SENSE_RISING && $rose(sync_b[3]))
		|-> $past(pin_eff[3], 2))
		else $error("low channel not synchronised");

	// Second synchroniser stage copies the first
	chk_sync_chain: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> sync_b == $past(sync_a))
		else $error("synchroniser chain broken");

	// Upper channels hold the pin value of the previous edge
	chk_high_sample: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> high_cur == $past(pin_eff[7:4]))
		else $error("upper sample stale");

	// The reserved code on a lower channel never detects anything
	chk_low_no_change: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sense_of(sense_all, 0) == ext_irq_pkg::SENSE_CHANGE) |-> !hit[0])
		else $error("reserved code detected an event");

	// Any change on an upper channel is an event
	chk_high_change: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sense_of(sense_all, 6) == ext_irq_pkg::SENSE_CHANGE && high_prev[2] != high_cur[2])
		|-> hit[6])
		else $error("change not detected");

	// A falling sample pair on an upper channel is an event
	chk_high_falling: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sense_of(sense_all, 4) == ext_irq_pkg::SENSE_FALLING && high_prev[0] && !high_cur[0])
		|-> hit[4])
		else $error("falling edge not detected");

	// Pins are read whatever their direction when no buffer is switched off
	chk_pin_output_read: assert property (@(posedge ref_clk) disable iff (!resetn)
		!sleep_active |-> pin_eff == ext_irq_pins)
		else $error("pin not observed");

	// Masked lower channels read low while asleep
	chk_sleep_buffer: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleep_active && !mask[2]) |-> !pin_eff[2])
		else $error("buffer not disabled in sleep");

	// Register port: read data, written fields and legacy hiding
	chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		!bus_rd |=> rdata == 8'h00)
		else $error("read data without strobe");

	// Flags read back as they stood at the strobe
	chk_flags_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bus_rd && bus_req.addr == ext_irq_pkg::OFS_FLAGS) |=> rdata == $past(flags))
		else $error("flag read mismatch");

	// Mask reads back as it stood at the strobe
	chk_mask_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bus_rd && bus_req.addr == ext_irq_pkg::OFS_MASK) |=> rdata == $past(mask))
		else $error("mask read mismatch");

	// Upper sense register takes the written byte
	chk_sense_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bus_wr && bus_req.addr == ext_irq_pkg::OFS_SENSE_HIGH)
		|=> sense_high == $past(bus_req.wdata))
		else $error("sense write lost");

	// Lower sense reads zero in legacy mode
	chk_legacy_reads: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bus_rd && legacy_mode && bus_req.addr == ext_irq_pkg::OFS_SENSE_LOW) |=> rdata == 8'h00)
		else $error("lower sense visible in legacy mode");

	// Lower sense ignores writes in legacy mode
	chk_legacy_no_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bus_wr && legacy_mode && bus_req.addr == ext_irq_pkg::OFS_SENSE_LOW) |=> $stable(sense_low))
		else $error("lower sense written in legacy mode");

	// Legacy mode keeps channels 3:0 at low level
	chk_legacy_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		legacy_mode |-> level_mode[3:0] == 4'hF)
		else $error("legacy channel not level sensed");

	// Wake filter: two ticks, only in power-down, held until power-down ends
	chk_wake_two_ticks: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(wake_req) |-> wake_cnt == ext_irq_pkg::WAKE_SAMPLES)
		else $error("wake too early");

	// Wake only starts on a watchdog tick
	chk_wake_needs_tick: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(wake_req) |-> $past(wdt_tick))
		else $error("wake without watchdog tick");

	// Leaving power-down drops the wake request
	chk_wake_only_pd: assert property (@(posedge ref_clk) disable iff (!resetn)
		!power_down |=> !wake_req)
		else $error("wake outside power-down");

	// Wake holds even if the level goes away
	chk_wake_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wake_req && power_down) |=> wake_req)
		else $error("wake dropped in power-down");

	// Sample counter saturates at the required count
	chk_wake_cnt_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
		wake_cnt <= ext_irq_pkg::WAKE_SAMPLES)
		else $error("wake counter overran");

	// Main scenarios worth seeing in a run
	cov_rising_low: cover property (@(posedge ref_clk) disable iff (!resetn) hit[3]);
	cov_change_high: cover property (@(posedge ref_clk) disable iff (!resetn)
		hit[6] && sense_of(sense_all, 6) == ext_irq_pkg::SENSE_CHANGE);
	cov_wake: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(wake_req));
	cov_wake_no_req: cover property (@(posedge ref_clk) disable iff (!resetn)
		startup_seen && !wake_level);
	cov_level_req: cover property (@(posedge ref_clk) disable iff (!resetn)
		irq_req[5] && level_mode[5]);
endmodule
`default_nettype wire

/* verif/pin_source.sv */
// Model of the external sources that drive the eight interrupt pins
`timescale 1ns/100ps
`default_nettype none
module pin_source (
	input  wire logic       ref_clk,
	input  wire logic [7:0] level_cmd,
	output var logic [7:0]  pins
);
	// Pins idle high; a commanded low is held until told otherwise
	initial pins = 8'hFF;
	always @(posedge ref_clk) begin
		pins <= level_cmd;
	end
endmodule
`default_nettype wire

/* verif/external_pin_interrupt_unit_test.sv */
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit_test;
	logic                  ref_clk;
	logic                  resetn;
	ext_irq_pkg::reg_req_s bus_req;
	logic [7:0]            rdata;
	logic [7:0]            pin_cmd;
	logic [7:0]            pin_lvl;
	logic                  gie;
	logic                  irq_ack;
	logic [2:0]            ack_ch;
	logic                  legacy_mode;
	logic                  sleep_active;
	logic                  startup_done;
	logic                  power_down;
	logic                  wdt_tick;
	logic [7:0]            irq_req;
	logic                  irq;
	logic                  wake_req;
	int                    mismatches;
	int                    tests_run;

	pin_source u_pin_source (.ref_clk(ref_clk), .level_cmd(pin_cmd), .pins(pin_lvl));

	external_pin_interrupt_unit u_external_pin_interrupt_unit (
		.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
		.ext_irq_pins(pin_lvl), .global_irq_enable(gie), .irq_ack(irq_ack),
		.irq_ack_channel(ack_ch), .legacy_mode(legacy_mode), .sleep_active(sleep_active),
		.power_down(power_down), .wdt_tick(wdt_tick), .startup_done(startup_done),
		.irq_req(irq_req), .irq(irq), .wake_req(wake_req)
	);

	// Free-running clock
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge ref_clk);
		bus_req.wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge ref_clk);
		bus_req.rd <= 1'h0;
		#1;
		chk(rdata, exp, what);
	endtask

	// Pin change, then enough cycles for sync, flag and request stages
	task automatic pins(input logic [7:0] v);
		@(posedge ref_clk);
		pin_cmd <= v;
		cyc(6);
	endtask

	task automatic tick();
		@(posedge ref_clk);
		wdt_tick <= 1'h1;
		@(posedge ref_clk);
		wdt_tick <= 1'h0;
	endtask

	// Watchdog sized well above the few hundred cycles the tests need
	initial begin
		#1ms;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		resetn = 1'h0;
		bus_req = '0;
		pin_cmd = 8'hFF;
		gie = 1'h0;
		irq_ack = 1'h0;
		ack_ch = 3'h0;
		legacy_mode = 1'h0;
		sleep_active = 1'h0;
		startup_done = 1'h0;
		power_down = 1'h0;
		wdt_tick = 1'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'h1;
		rd(8'h58, 8'h00, "flags reset");
		rd(8'h59, 8'h00, "mask reset");
		rd(8'h5A, 8'h00, "sense high reset");
		rd(8'h6A, 8'h00, "sense low reset");
		rd(8'h70, 8'h00, "unmapped read");
		$display("test reset values done");
		// ch4 falling, ch5 level, ch6 any change, ch7 rising
		wr(8'h5A, 8'hD2);
		rd(8'h5A, 8'hD2, "sense high");
		wr(8'h59, 8'hF0);
		gie <= 1'h1;
		wr(8'h58, 8'hFF);
		pins(8'hEF);
		rd(8'h58, 8'h10, "ch4 falling");
		chk({7'h00, irq}, 8'h01, "irq on flag");
		pins(8'h6F);
		rd(8'h58, 8'h10, "ch7 falls under rising");
		pins(8'hEF);
		rd(8'h58, 8'h90, "ch7 rising");
		pins(8'hAF);
		rd(8'h58, 8'hD0, "ch6 change");
		wr(8'h58, 8'h00);
		rd(8'h58, 8'hD0, "zero write keeps");
		@(posedge ref_clk);
		irq_ack <= 1'h1;
		ack_ch <= 3'h7;
		@(posedge ref_clk);
		irq_ack <= 1'h0;
		rd(8'h58, 8'h50, "ack clears ch7");
		@(posedge ref_clk);
		gie <= 1'h0;
		cyc(3);
		chk({7'h00, irq}, 8'h00, "global off");
		wr(8'h58, 8'hFF);
		rd(8'h58, 8'h00, "W1C clear");
		@(posedge ref_clk);
		gie <= 1'h1;
		$display("test upper edges done");
		pins(8'h8F);
		chk(irq_req, 8'h20, "level request");
		rd(8'h58, 8'h00, "level flag held 0");
		cyc(20);
		chk(irq_req, 8'h20, "level still low");
		pins(8'hAF);
		chk(irq_req, 8'h00, "level released");
		$display("test level done");
		// ch3 rising, ch0 reserved code; lower channels stay masked while changed
		wr(8'h6A, 8'hC1);
		wr(8'h58, 8'h0F);
		pins(8'hAE);
		pins(8'hAF);
		rd(8'h58, 8'h00, "reserved code");
		pins(8'hA7);
		pins(8'hAF);
		rd(8'h58, 8'h08, "ch3 rising");
		wr(8'h58, 8'h08);
		legacy_mode <= 1'h1;
		wr(8'h6A, 8'hFF);
		rd(8'h6A, 8'h00, "legacy hides");
		@(posedge ref_clk);
		legacy_mode <= 1'h0;
		rd(8'h6A, 8'hC1, "legacy write lost");
		$display("test lower edges done");
		// Masked lower pins read low in sleep; waking them gives a rising edge
		@(posedge ref_clk);
		sleep_active <= 1'h1;
		cyc(6);
		rd(8'h58, 8'h00, "sleep fall ignored");
		@(posedge ref_clk);
		sleep_active <= 1'h0;
		cyc(6);
		rd(8'h58, 8'h08, "buffer change sets flag");
		wr(8'h58, 8'h08);
		$display("test sleep done");
		power_down <= 1'h1;
		pins(8'h8F);
		tick();
		cyc(2);
		chk({7'h00, wake_req}, 8'h00, "one sample");
		tick();
		cyc(2);
		chk({7'h00, wake_req}, 8'h01, "two samples");
		chk(irq_req, 8'h00, "level blocked in power-down");
		@(posedge ref_clk);
		startup_done <= 1'h1;
		pins(8'hAF);
		chk({7'h00, wake_req}, 8'h01, "wake held");
		@(posedge ref_clk);
		power_down <= 1'h0;
		startup_done <= 1'h0;
		cyc(4);
		chk(irq_req, 8'h00, "no request");
		chk({7'h00, wake_req}, 8'h00, "wake dropped");
		$display("test wake done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
